// >>> core/pfcu_pkg.sv
package pfcu_pkg;
	// bus addressing
	localparam logic [6:0] ROM_ADDR = 7'h0B; // fixed answer address while in rom mode
	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
	localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
	localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
	localparam logic [7:0] CMD_RAIL_CONFIG = 8'hD2;
	localparam logic [7:0] CMD_VOUT_CONFIG = 8'hD4;
	localparam logic [7:0] CMD_ENABLE_ROM = 8'hD9;
	localparam logic [7:0] CMD_DF_ERASE = 8'hF0;
	localparam logic [7:0] CMD_DF_POINTER = 8'hF1;
	localparam logic [7:0] CMD_DF_WRITE = 8'hF2;
	localparam logic [7:0] CMD_DF_READ = 8'hF3;
	localparam logic [7:0] CMD_SUM_ERASE = 8'hF4;
	localparam logic [7:0] CMD_SUM_WRITE = 8'hF5;
	localparam logic [7:0] CMD_SUM_READ = 8'hF6;
	localparam logic [7:0] CMD_EXECUTE = 8'hF7;
	// flash words and layout
	localparam int DF_WORDS = 16;
	localparam int DF_AW = 4;
	localparam logic [3:0] CFG_MANT_IDX = 4'h0;
	localparam logic [3:0] CFG_MODE_IDX = 4'h1;
	localparam logic [3:0] LOG_BASE_IDX = 4'h8;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [15:0] FACTORY_WORD = 16'hAAAA;
	localparam logic [15:0] CLEARED_SUM = 16'h0000;
	localparam logic [15:0] PROG_SUM_CALC = 16'h5A3C; // arbitrary program image sum
	// link framing
	localparam logic [2:0] CNT_MAX = 3'h5;
	localparam logic [1:0] RD_PEC_IDX = 2'h2;
	// pec crc-8
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	typedef enum logic [2:0] {
		PF_BOOT = 3'b001,
		PF_RUN = 3'b010,
		PF_ROM = 3'b100
	} pfcu_state_e;
endpackage

// >>> core/pfcu_pec_crc.sv
`timescale 1ns/10ps
module pfcu_pec_crc import pfcu_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] din,
	output logic [7:0] crc
);
	logic [7:0] stage [9];

	// msb-first crc, one stage per bit
	assign stage[0] = crc ^ din;
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign stage[i+1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ CRC_POLY)
			: {stage[i][6:0], 1'b0};
	end

	// clear wins so a new frame never inherits a stale sum
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			crc <= CRC_INIT;
		end else if (en) begin
			crc <= stage[8];
		end
	end
endmodule

// >>> core/pfcu_config_update.sv
`timescale 1ns/10ps
// What this block does
// - during a normal-mode download, no fault logging into data flash.
// - during a download, vout status still updates on monitored faults.
// - in rom mode there is no conversion, monitoring or sequencing.
// - rom entry clears the program sum, resets, and stays in rom.
// - a maker-specific command starts rom entry.
// - rom mode answers only at address eleven.
// - rom mode rejects writes without pec; reads always end with pec.
// - program mode takes writes with or without pec.
// - df write programs only erased words; store overwrites config words; sum needs segment erase.
// - rail configuration takes effect only after a reset.
// - config writes touch ram only, never flash.
// - reset drops ram config and reloads it from flash.
// - store command copies ram config into flash.
// - vout mantissa plus exponent stored as q16.16 fixed point.
// - factory cleared data flash holds the 1010 pattern.
module pfcu_config_update import pfcu_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic factory_clear,
	input wire logic [6:0] prog_addr,
	input wire logic frame_start,
	input wire logic frame_byte_valid,
	input wire logic [7:0] frame_byte,
	input wire logic frame_stop,
	input wire logic rd_req,
	input wire logic vout_fault,
	output logic addr_ack,
	output logic xfer_done,
	output logic xfer_reject,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rom_mode,
	output logic conv_enable,
	output logic download_active,
	output logic status_vout,
	output logic [31:0] vout_setpoint,
	output logic [3:0] active_rails
);
	pfcu_state_e state, next_state;
	logic [15:0] df [DF_WORDS];
	logic [15:0] prog_sum;
	logic [7:0] wbuf [4];
	logic [2:0] cnt;
	logic [1:0] rd_idx;
	logic sel, rd_phase, wprot;
	logic [3:0] df_ptr, log_ptr;
	logic [15:0] ram_mant;
	logic [4:0] ram_exp;
	logic [3:0] ram_rails;
	logic [31:0] ram_q;
	logic [7:0] crc;

	// pmbus linear value to q16.16: flipping the exponent msb adds 16
	function automatic logic [31:0] to_fixed(input logic [15:0] m, input logic [4:0] e);
		logic signed [47:0] w;
		w = {{32{m[15]}}, m};
		w = w <<< {~e[4], e[3:0]};
		return w[31:0]; // large values wrap, a known limitation
	endfunction

	function automatic logic [2:0] cmd_len(input logic [7:0] c);
		case (c)
			CMD_VOUT_COMMAND, CMD_VOUT_CONFIG, CMD_RAIL_CONFIG, CMD_WRITE_PROTECT,
			CMD_DF_POINTER, CMD_DF_WRITE, CMD_SUM_WRITE: return 3'h2;
			default: return 3'h0;
		endcase
	endfunction

	// address match and frame qualifiers
	wire in_rom = (state == PF_ROM);
	wire in_run = (state == PF_RUN);
	wire [6:0] my_addr = in_rom ? ROM_ADDR : prog_addr;
	wire addr_hit = frame_start && (frame_byte[7:1] == my_addr) && (state != PF_BOOT);
	wire wr_byte = frame_byte_valid && sel && !rd_phase;
	wire rd_take = rd_req && sel && rd_phase;
	wire wr_done = frame_stop && sel && !rd_phase && (cnt != 3'h0);
	wire crc_en = addr_hit || wr_byte || (rd_take && rd_idx < RD_PEC_IDX);

	// command decode
	wire [7:0] cmd = wbuf[0];
	wire [15:0] wdata = {wbuf[2], wbuf[1]};
	wire [2:0] len = cmd_len(cmd);
	wire has_pec = (cnt == len + 3'h2);
	wire no_pec = (cnt == len + 3'h1);
	wire form_ok = (has_pec && crc == 8'h00) || (no_pec && !in_rom);
	wire df_cmd = (cmd == CMD_DF_ERASE) || (cmd == CMD_DF_POINTER) ||
		(cmd == CMD_DF_WRITE) || (cmd == CMD_DF_READ);
	wire rom_cmd = (cmd == CMD_SUM_ERASE) || (cmd == CMD_SUM_WRITE) ||
		(cmd == CMD_SUM_READ) || (cmd == CMD_EXECUTE);
	wire run_cmd = (cmd == CMD_CLEAR_FAULTS) || (cmd == CMD_WRITE_PROTECT) ||
		(cmd == CMD_STORE_DEFAULT_ALL) || (cmd == CMD_VOUT_COMMAND) ||
		(cmd == CMD_VOUT_CONFIG) || (cmd == CMD_RAIL_CONFIG) || (cmd == CMD_ENABLE_ROM);
	wire allowed = in_rom ? (df_cmd || rom_cmd) : (in_run && (df_cmd || run_cmd));
	// protection only binds in program mode; the rom loader is trusted
	wire df_open = in_rom || !wprot;
	wire cond_ok = ((cmd == CMD_DF_ERASE) ? df_open : 1'b1) &&
		((cmd == CMD_DF_WRITE) ? (df_open && df[df_ptr] == ERASED_WORD) : 1'b1) &&
		((cmd == CMD_SUM_WRITE) ? (prog_sum == ERASED_WORD) : 1'b1);
	wire go = wr_done && form_ok && allowed && cond_ok;
	wire df_erase = go && (cmd == CMD_DF_ERASE);
	wire df_wr_go = go && (cmd == CMD_DF_WRITE);
	wire store_go = go && (cmd == CMD_STORE_DEFAULT_ALL);
	wire soft_boot = go && ((cmd == CMD_ENABLE_ROM) || (cmd == CMD_EXECUTE));
	wire sum_ok = (prog_sum == PROG_SUM_CALC);

	// fault logging, held off while a download is open
	wire [3:0] log_idx = LOG_BASE_IDX | log_ptr;
	wire log_go = vout_fault && in_run && !download_active &&
		(df[log_idx] == ERASED_WORD);

	// read word and byte select
	wire [15:0] rd_word = (cmd == CMD_VOUT_COMMAND) ? ram_mant :
		(cmd == CMD_VOUT_CONFIG) ? {11'h000, ram_exp} :
		(cmd == CMD_RAIL_CONFIG) ? {12'h000, ram_rails} :
		(cmd == CMD_DF_READ) ? df[df_ptr] :
		(cmd == CMD_SUM_READ) ? PROG_SUM_CALC : ERASED_WORD;
	wire [7:0] rd_byte = (rd_idx == 2'h0) ? rd_word[7:0] :
		(rd_idx == 2'h1) ? rd_word[15:8] :
		(rd_idx == RD_PEC_IDX) ? crc : 8'hFF;

	// boot decides rom or run from the stored program sum
	assign next_state = (state == PF_BOOT) ? (sum_ok ? PF_RUN : PF_ROM) :
		soft_boot ? PF_BOOT : state;

	pfcu_pec_crc u_pec (
		.clk(clk),
		.rst(rst),
		.clr(frame_stop),
		.en(crc_en),
		.din(rd_take ? rd_byte : frame_byte),
		.crc(crc)
	);

	// nonvolatile words: no reset, only factory clear, erase and programming
	for (genvar i = 0; i < DF_WORDS; i++) begin : g_df
		localparam logic [DF_AW-1:0] IDX = DF_AW'(i);
		always_ff @(posedge clk) begin
			if (factory_clear) begin
				df[i] <= FACTORY_WORD;
			end else if (df_erase) begin
				df[i] <= ERASED_WORD;
			end else if (store_go && IDX == CFG_MANT_IDX) begin
				df[i] <= ram_mant;
			end else if (store_go && IDX == CFG_MODE_IDX) begin
				df[i] <= {ram_exp, 7'h00, ram_rails};
			end else if (df_wr_go && df_ptr == IDX) begin
				df[i] <= wdata;
			end else if (log_go && log_idx == IDX) begin
				df[i] <= ram_mant;
			end
		end
	end

	// program sum: cleared on rom entry, erased then rebuilt by the loader
	always_ff @(posedge clk) begin
		if (factory_clear) begin
			prog_sum <= PROG_SUM_CALC;
		end else if (go && cmd == CMD_ENABLE_ROM) begin
			prog_sum <= CLEARED_SUM;
		end else if (go && cmd == CMD_SUM_ERASE) begin
			prog_sum <= ERASED_WORD;
		end else if (go && cmd == CMD_SUM_WRITE) begin
			prog_sum <= wdata;
		end
	end

	// mode state and mode outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= PF_BOOT;
			rom_mode <= 1'b0;
			conv_enable <= 1'b0;
		end else begin
			state <= next_state;
			rom_mode <= (next_state == PF_ROM);
			conv_enable <= (next_state == PF_RUN);
		end
	end

	// frame capture
	always_ff @(posedge clk) begin
		if (rst) begin
			sel <= 1'b0;
			rd_phase <= 1'b0;
			cnt <= 3'h0;
			rd_idx <= 2'h0;
			wbuf <= '{default: 8'h00};
		end else if (frame_start) begin
			sel <= addr_hit;
			rd_phase <= frame_byte[0];
			rd_idx <= 2'h0;
			if (!frame_byte[0]) begin
				cnt <= 3'h0;
			end
		end else if (wr_byte) begin
			if (cnt < 3'h4) begin
				wbuf[cnt[1:0]] <= frame_byte;
			end
			cnt <= (cnt == CNT_MAX) ? cnt : cnt + 3'h1; // overlong frames stay rejected
		end else if (rd_take) begin
			rd_idx <= (rd_idx == 2'h3) ? rd_idx : rd_idx + 2'h1;
		end else if (frame_stop) begin
			sel <= 1'b0;
		end
	end

	// link answers
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_ack <= 1'b0;
			xfer_done <= 1'b0;
			xfer_reject <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			addr_ack <= addr_hit;
			xfer_done <= go;
			xfer_reject <= wr_done && !go;
			rd_data <= rd_take ? rd_byte : rd_data;
			rd_valid <= rd_take;
		end
	end

	// volatile config, reloaded from flash on every boot
	always_ff @(posedge clk) begin
		if (state == PF_BOOT) begin
			ram_mant <= df[CFG_MANT_IDX];
			ram_exp <= df[CFG_MODE_IDX][15:11];
			ram_rails <= df[CFG_MODE_IDX][3:0];
			ram_q <= to_fixed(df[CFG_MANT_IDX], df[CFG_MODE_IDX][15:11]);
			active_rails <= df[CFG_MODE_IDX][3:0];
		end else if (go && cmd == CMD_VOUT_COMMAND) begin
			ram_mant <= wdata;
			ram_q <= to_fixed(wdata, ram_exp);
		end else if (go && cmd == CMD_VOUT_CONFIG) begin
			ram_exp <= wdata[4:0];
			ram_q <= to_fixed(ram_mant, wdata[4:0]);
		end else if (go && cmd == CMD_RAIL_CONFIG) begin
			ram_rails <= wdata[3:0];
		end
	end

	// housekeeping and status
	always_ff @(posedge clk) begin
		if (rst || state == PF_BOOT) begin
			wprot <= 1'b1;
			download_active <= 1'b0;
			df_ptr <= 4'h0;
			log_ptr <= 4'h0;
			status_vout <= 1'b0;
			vout_setpoint <= 32'h0000_0000;
		end else begin
			if (go && cmd == CMD_WRITE_PROTECT) begin
				wprot <= |wdata;
			end
			if (in_run && (df_erase || df_wr_go)) begin
				download_active <= 1'b1;
			end
			if (go && cmd == CMD_DF_POINTER) begin
				df_ptr <= wdata[3:0];
			end else if (df_wr_go || (rd_take && rd_idx == 2'h1 && cmd == CMD_DF_READ)) begin
				df_ptr <= df_ptr + 4'h1;
			end
			if (log_go) begin
				log_ptr <= {1'b0, log_ptr[2:0] + 3'h1};
			end
			// a fault in the clearing cycle still sets the flag
			if (vout_fault && in_run) begin
				status_vout <= 1'b1;
			end else if (go && cmd == CMD_CLEAR_FAULTS) begin
				status_vout <= 1'b0;
			end
			vout_setpoint <= in_run ? ram_q : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	rom_no_conv_a: assert property (rom_mode |-> !conv_enable)
		else $error("conversion enabled in rom mode");
	rom_addr_a: assert property (frame_start && in_rom |=>
		addr_ack == ($past(frame_byte[7:1]) == ROM_ADDR))
		else $error("rom mode address answer wrong");
	rom_pec_a: assert property (wr_done && in_rom && !has_pec |=> xfer_reject)
		else $error("rom write without pec accepted");
	prog_nopec_a: assert property (wr_done && in_run && no_pec &&
		cmd == CMD_VOUT_COMMAND |=> xfer_done)
		else $error("program mode write without pec refused");
	log_hold_a: assert property (download_active && vout_fault && !df_erase &&
		!df_wr_go && !factory_clear |=>
		$stable(df[$past(log_idx)]))
		else $error("fault logged during download");
	status_set_a: assert property (vout_fault && in_run |=> status_vout)
		else $error("vout status not set");
	rom_entry_a: assert property (go && cmd == CMD_ENABLE_ROM |=>
		state == PF_BOOT ##1 state == PF_ROM [*2])
		else $error("rom entry did not stay in rom");
	store_copy_a: assert property (store_go |=> df[CFG_MANT_IDX] == $past(ram_mant))
		else $error("store did not copy ram");
	ram_only_a: assert property (go && cmd == CMD_VOUT_COMMAND && !factory_clear |=>
		$stable(df[CFG_MANT_IDX]))
		else $error("config write reached flash");
	fixed_form_a: assert property (go && cmd == CMD_VOUT_COMMAND && !in_rom |=>
		ram_q == to_fixed($past(wdata), ram_exp) ##1 vout_setpoint == $past(ram_q))
		else $error("fixed point value wrong");
	boot_load_a: assert property (state == PF_BOOT |=> ram_mant == $past(df[CFG_MANT_IDX]))
		else $error("boot did not restore ram");
	rails_hold_a: assert property (state != PF_BOOT |=> $stable(active_rails))
		else $error("rails changed without reset");
	sum_prog_a: assert property (go && cmd == CMD_SUM_WRITE |->
		$past(prog_sum) == ERASED_WORD || $past(go))
		else $error("sum written over unerased word");
endmodule

// >>> tb/pfcu_host_model.sv
`timescale 1ns/10ps
module pfcu_host_model import pfcu_pkg::*; (
	input wire logic clk,
	input wire logic addr_ack,
	input wire logic xfer_done,
	input wire logic xfer_reject,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	output logic frame_start,
	output logic frame_byte_valid,
	output logic [7:0] frame_byte,
	output logic frame_stop,
	output logic rd_req
);
	logic [7:0] pec = CRC_INIT;
	// bus quiet from time zero
	initial {frame_start, frame_byte_valid, frame_stop, rd_req, frame_byte} = 12'h000;
	// crc-8 kept apart from the design so a shared slip cannot hide
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? CRC_POLY : 8'h00);
		return r;
	endfunction
	// f = {start, byte, stop, read}; idle lanes get the inverse so stale data never matches
	task automatic drive(input logic [3:0] f, input logic [7:0] b);
		@(posedge clk);
		#1;
		{frame_start, frame_byte_valid, frame_stop, rd_req} = f;
		frame_byte = b;
		if (f[3] | f[2]) pec = crc(pec, b);
	endtask
	// write frame, r = {ack, done, reject}; pm = {bad, with pec}; any address, ours or not
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input int n,
		input logic [15:0] d, input logic [1:0] pm, output logic [2:0] r);
		pec = CRC_INIT;
		drive(4'h8, {a, 1'b0});
		drive(4'h4, cmd);
		r[2] = addr_ack;
		for (int i = 0; i < n; i++) drive(4'h4, d[8*i+:8]);
		if (pm[0]) drive(4'h4, pm[1] ? ~pec : pec);
		drive(4'h2, ~frame_byte);
		drive(4'h0, ~frame_byte);
		r[1:0] = {xfer_done, xfer_reject};
	endtask
	// read frame: low, high, pec; ep is the pec due over the expected word
	task automatic rd(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] e,
		output logic ok, output logic [23:0] got, output logic [7:0] ep);
		pec = CRC_INIT;
		drive(4'h8, {a, 1'b0});
		drive(4'h4, cmd);
		drive(4'h8, {a, 1'b1});
		drive(4'h0, ~frame_byte);
		ok = addr_ack;
		for (int i = 0; i < 3; i++) begin
			drive(4'h1, ~frame_byte);
			drive(4'h0, ~frame_byte);
			ok = ok & rd_valid;
			got[8*i+:8] = rd_data;
		end
		ep = crc(crc(pec, e[7:0]), e[15:8]);
		drive(4'h2, ~frame_byte);
		drive(4'h0, ~frame_byte);
	endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb import pfcu_pkg::*;;
	localparam logic [6:0] PA = 7'h1C;
	localparam logic [2:0] OK = 3'h6;
	localparam logic [2:0] NO = 3'h5;
	logic clk, rst, factory_clear, vout_fault, frame_start, frame_byte_valid, frame_stop;
	logic rd_req, addr_ack, xfer_done, xfer_reject, rd_valid, rom_mode, conv_enable;
	logic download_active, status_vout;
	logic [6:0] prog_addr;
	logic [7:0] frame_byte, rd_data;
	logic [31:0] vout_setpoint;
	logic [3:0] active_rails;
	int err_count = 0;
	int tests_run = 0;
	pfcu_config_update dut (.*);
	pfcu_host_model host (.*);
	// 40 mhz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// bench changes land 1 ns after a rising edge; results widened, unknowns never match
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [6:0] a, input logic [7:0] cmd, input int n,
		input logic [15:0] d, input logic [1:0] pm, input logic [2:0] er);
		logic [2:0] r;
		host.wr(a, cmd, n, d, pm, r);
		chk(32'(r), 32'(er));
	endtask
	task automatic rx(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] e);
		logic ok;
		logic [23:0] got;
		logic [7:0] ep;
		host.rd(a, cmd, e, ok, got, ep);
		chk(32'({ok, got}), {8'h01, ep, e});
	endtask
	task automatic rdf(input logic [3:0] i, input logic [15:0] e);
		w(PA, CMD_DF_POINTER, 2, {12'h000, i}, 2'h0, OK);
		rx(PA, CMD_DF_READ, e);
	endtask
	task automatic fault();
		vout_fault = 1'b1;
		step(1);
		vout_fault = 1'b0;
		step(1);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(3);
	endtask
	// factory image runs with rails and words from the cleared pattern
	task automatic t_factory();
		chk(32'({rom_mode, conv_enable, active_rails}), 32'h1A);
		rdf(4'h0, FACTORY_WORD);
	endtask
	// exponent -2, both signs; a bad pec must leave the value alone
	task automatic t_vout();
		w(PA, CMD_VOUT_CONFIG, 2, 16'h001E, 2'h1, OK);
		w(PA, CMD_VOUT_COMMAND, 2, 16'h0140, 2'h0, OK);
		step(1);
		chk(vout_setpoint, 32'h00500000);
		w(PA, CMD_VOUT_COMMAND, 2, 16'hFF80, 2'h1, OK);
		w(PA, CMD_VOUT_COMMAND, 2, 16'h0200, 2'h3, NO);
		step(1);
		chk(vout_setpoint, 32'hFFE00000);
	endtask
	// edits live in ram until stored; rails wait for a reset
	task automatic t_ram();
		w(PA, CMD_RAIL_CONFIG, 2, 16'h0003, 2'h0, OK);
		rdf(4'h0, FACTORY_WORD);
		do_reset();
		rx(PA, CMD_VOUT_COMMAND, FACTORY_WORD);
		w(PA, CMD_VOUT_COMMAND, 2, 16'h0140, 2'h0, OK);
		w(PA, CMD_RAIL_CONFIG, 2, 16'h0003, 2'h0, OK);
		w(PA, CMD_STORE_DEFAULT_ALL, 0, 16'h0000, 2'h0, OK);
		rdf(4'h0, 16'h0140);
		chk(32'(active_rails), 32'hA);
		do_reset();
		chk(32'(active_rails), 32'h3);
		rx(PA, CMD_VOUT_COMMAND, 16'h0140);
	endtask
	// protected erase refused; during the download faults set status but never log
	task automatic t_dl();
		w(PA, CMD_DF_ERASE, 0, 16'h0000, 2'h0, NO);
		w(PA, CMD_WRITE_PROTECT, 2, 16'h0000, 2'h0, OK);
		w(PA, CMD_DF_ERASE, 0, 16'h0000, 2'h0, OK);
		step(1);
		chk(32'(download_active), 32'h1);
		w(PA, CMD_DF_POINTER, 2, 16'h0000, 2'h0, OK);
		w(PA, CMD_DF_WRITE, 2, 16'h1234, 2'h0, OK);
		w(PA, CMD_DF_POINTER, 2, 16'h0000, 2'h0, OK);
		w(PA, CMD_DF_WRITE, 2, 16'h5678, 2'h0, NO);
		fault();
		chk(32'(status_vout), 32'h1);
		w(PA, CMD_CLEAR_FAULTS, 0, 16'h0000, 2'h0, OK);
		chk(32'(status_vout), 32'h0);
		rdf(4'h0, 16'h1234);
		rdf(4'h8, ERASED_WORD);
		do_reset();
		chk(32'({conv_enable, status_vout}), 32'h2);
		rx(PA, CMD_VOUT_COMMAND, 16'h1234);
		// with the download closed the same fault must reach the log
		fault();
		rdf(4'h8, 16'h1234);
	endtask
	// rom entry survives reset, fixed address, pec required, sum rebuilt, back to run
	task automatic t_rom();
		logic [2:0] r;
		w(PA, CMD_ENABLE_ROM, 0, 16'h0000, 2'h0, OK);
		step(4);
		chk(32'({rom_mode, conv_enable}), 32'h2);
		fault();
		chk(32'(status_vout), 32'h0);
		do_reset();
		chk(32'(rom_mode), 32'h1);
		host.wr(PA, CMD_SUM_ERASE, 0, 16'h0000, 2'h1, r);
		chk(32'(r), 32'h0);
		w(ROM_ADDR, CMD_SUM_ERASE, 0, 16'h0000, 2'h0, NO);
		w(ROM_ADDR, CMD_SUM_WRITE, 2, PROG_SUM_CALC, 2'h1, NO);
		rx(ROM_ADDR, CMD_SUM_READ, PROG_SUM_CALC);
		w(ROM_ADDR, CMD_SUM_ERASE, 0, 16'h0000, 2'h1, OK);
		w(ROM_ADDR, CMD_SUM_WRITE, 2, PROG_SUM_CALC, 2'h1, OK);
		w(ROM_ADDR, CMD_EXECUTE, 0, 16'h0000, 2'h1, OK);
		step(4);
		chk(32'({rom_mode, conv_enable}), 32'h1);
		rx(PA, CMD_VOUT_COMMAND, 16'h1234);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	// reset held 16 cycles; factory image loaded while reset is high
	initial begin
		rst = 1'b1;
		factory_clear = 1'b0;
		vout_fault = 1'b0;
		prog_addr = PA;
		step(2);
		factory_clear = 1'b1;
		step(1);
		factory_clear = 1'b0;
		step(13);
		rst = 1'b0;
		step(3);
		t_factory();
		t_vout();
		t_ram();
		t_dl();
		t_rom();
		wrap_up();
	end
endmodule
